// File: bsc_top.sv
// bus mode register fed by power-up straps
`timescale 1ns/100ps
`include "bsc_map.svh"
module bsc_top #(
    parameter int ADDR_W  = `BSC_ADDR_W,
    parameter int DATA_W  = 64,
    parameter int STRAP_W = 4
) (
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire logic              POWER_UP_RESET_N,
    input  wire logic [3:0]        STRAP,
    input  wire logic              HARD_RESET,
    input  wire logic              FW_BUS_RESET_RELEASE,
    input  wire logic              BUS_SPEED_SENSE_IN,
    input  wire logic              ARB_SIXTH_ENABLE_REQ,
    input  wire bsc_pkg::bsc_req_t REQ,
    output logic [63:0]            RDATA,
    output logic                   RVALID,
    output logic                   BUS_SPEED_O,
    output logic                   BUS_SPEED_OE,
    output logic                   BUS_RESET_N,
    output logic                   ARB_SIXTH_ENABLE,
    output logic                   NARROW_INITIATOR,
    output logic                   PAD_HIGH_VOLT,
    output logic                   GFX_BUS,
    output bsc_pkg::bsc_opsel_t    BUS_OPERATING_SELECT
);
    import bsc_pkg::*;

    // the register map, the request struct and the strap table are fixed
    // in size; any other value would leave the decoder or bus mismatched
    if (ADDR_W != `BSC_ADDR_W || DATA_W != 64 || STRAP_W != 4) begin : g_bad
        $error("unsupported parameter values");
    end

    logic [3:0] strap_q;
    logic       pur_n_q;
    logic       force_low_q;
    logic       narrow_q;
    bsc_opsel_t opsel_q;
    logic       reset_held_q;
    bsc_cfg_t   cfg;
    logic [63:0] mode_word;
    logic       hit;

    bsc_decode u_dec (
        .code (strap_q),
        .cfg  (cfg)
    );

    // capture straps on the rising edge of power-up reset; kept through
    // a hard reset, but a later RST_N assertion clears the captured code to zero
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pur_n_q <= 1'b0;
            strap_q <= 4'h0;
        end else begin
            pur_n_q <= POWER_UP_RESET_N;
            if (POWER_UP_RESET_N && !pur_n_q) begin
                strap_q <= STRAP;
            end
        end
    end

    function automatic logic wr_byte(input bsc_req_t r, input int b);
        return r.wr && r.addr == `BSC_MODE_OFFSET && r.be[b];
    endfunction

    assign hit = (REQ.addr == `BSC_MODE_OFFSET);

    // writable controls; only bits 8..11 are writable, strap bits ignore
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            force_low_q <= 1'b0;
            narrow_q    <= 1'b0;
            opsel_q     <= BSC_OP_PCI;
        end else if (wr_byte(REQ, 1)) begin
            force_low_q <= REQ.wdata[`BSC_BIT_FORCE_LOW];
            opsel_q     <= bsc_opsel_t'(REQ.wdata[`BSC_BIT_OPSEL_HI:
                                                  `BSC_BIT_OPSEL_LO]);
            narrow_q    <= REQ.wdata[`BSC_BIT_NARROW];
        end
    end

    // read view of the bus mode register
    always_comb begin
        mode_word = '0;
        mode_word[`BSC_BIT_GFX]         = cfg.gfx_bus;
        mode_word[`BSC_BIT_OLR_SINGLE]  = cfg.olr_single;
        mode_word[`BSC_BIT_OLR_DUAL]    = cfg.olr_dual;
        mode_word[`BSC_BIT_FULL_REQ]    = cfg.full_req;
        mode_word[`BSC_BIT_BOOT]        = cfg.boot_from_bus;
        mode_word[`BSC_BIT_DHL_N]       = cfg.double_host_link_n;
        mode_word[`BSC_BIT_PAD_VDDQ]    = cfg.pad_vddq;
        mode_word[`BSC_BIT_SPEED_SENSE] = BUS_SPEED_SENSE_IN &&
                                          !cfg.full_req;
        mode_word[`BSC_BIT_FORCE_LOW]   = force_low_q;
        mode_word[`BSC_BIT_OPSEL_HI:`BSC_BIT_OPSEL_LO] = opsel_q;
        mode_word[`BSC_BIT_NARROW]      = narrow_q;
    end

    // read answer one cycle after the request; unmapped offsets read zero
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA  <= 64'h0000_0000_0000_0000;
            RVALID <= 1'b0;
        end else begin
            RVALID <= REQ.rd;
            RDATA  <= (REQ.rd && hit) ? mode_word : 64'h0000_0000_0000_0000;
        end
    end

    // bus reset: held until a hard reset ends on boot straps, or firmware
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            reset_held_q <= 1'b1;
        end else if (HARD_RESET) begin
            reset_held_q <= 1'b1;
        end else if (reset_held_q && cfg.boot_from_bus && pur_n_q) begin
            reset_held_q <= 1'b0;
        end else if (FW_BUS_RESET_RELEASE) begin
            reset_held_q <= 1'b0;
        end
    end

    // speed pin: only ever pulled low, never driven high; with six
    // requesters the pin is left alone whatever software has written
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            BUS_SPEED_O  <= 1'b0;
            BUS_SPEED_OE <= 1'b0;
        end else begin
            BUS_SPEED_O  <= 1'b0;
            BUS_SPEED_OE <= force_low_q && !cfg.full_req;
        end
    end

    // bus reset pin; one register behind the held flag, so a hard reset
    // shows on the pin two edges after it is seen
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            BUS_RESET_N <= 1'b0;
        end else begin
            BUS_RESET_N <= !reset_held_q;
        end
    end

    // sixth arbitration slot; the software request alone cannot open it
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ARB_SIXTH_ENABLE <= 1'b0;
        end else begin
            ARB_SIXTH_ENABLE <= ARB_SIXTH_ENABLE_REQ && cfg.full_req;
        end
    end

    // initiator width restriction
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            NARROW_INITIATOR <= 1'b0;
        end else begin
            NARROW_INITIATOR <= narrow_q;
        end
    end

    // pad steering; resets to the higher voltage, the safe choice
    // before straps are known since the lower one could overstress nothing
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PAD_HIGH_VOLT <= 1'b1;
        end else begin
            PAD_HIGH_VOLT <= cfg.pad_vddq;
        end
    end

    // graphics bus flag for the bus logic
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            GFX_BUS <= 1'b0;
        end else begin
            GFX_BUS <= cfg.gfx_bus;
        end
    end

    // operating field copy for the bus logic
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            BUS_OPERATING_SELECT <= BSC_OP_PCI;
        end else begin
            BUS_OPERATING_SELECT <= opsel_q;
        end
    end
endmodule

// File: bsc_map.svh
// register map, field positions, reset values and strap codes
`ifndef BSC_MAP_SVH
`define BSC_MAP_SVH
`define BSC_MODE_OFFSET      12'h0620
`define BSC_ADDR_W           12
`define BSC_BIT_GFX          0
`define BSC_BIT_OLR_SINGLE   1
`define BSC_BIT_OLR_DUAL     2
`define BSC_BIT_FULL_REQ     3
`define BSC_BIT_BOOT         4
`define BSC_BIT_DHL_N        5
`define BSC_BIT_PAD_VDDQ     6
`define BSC_BIT_SPEED_SENSE  7
`define BSC_BIT_FORCE_LOW    8
`define BSC_BIT_OPSEL_LO     9
`define BSC_BIT_OPSEL_HI     10
`define BSC_BIT_NARROW       11
`define BSC_OPSEL_RESET      2'h0
`define BSC_CODE_GFX_LO      4'h8
`define BSC_CODE_GFX_HI      4'h9
`define BSC_CODE_PCI6_A      4'hE
`define BSC_CODE_PCI6_BOOT   4'hC
`define BSC_CODE_BOOT_X      4'hD
`define BSC_CODE_UNUSED      4'hA
`define BSC_CODE_SINGLE_A    4'hF
`define BSC_CODE_DUAL_A      4'hB
`endif

// File: bsc_pkg.sv
// types for the strap configuration block
package bsc_pkg;
    typedef enum logic [1:0] {
        BSC_OP_PCI     = 2'h0,
        BSC_OP_X100    = 2'h1,
        BSC_OP_X66     = 2'h2,
        BSC_OP_X133    = 2'h3
    } bsc_opsel_t;

    typedef struct packed {
        logic gfx_bus;
        logic olr_single;
        logic olr_dual;
        logic full_req;
        logic boot_from_bus;
        logic double_host_link_n;
        logic pad_vddq;
        logic reserved_code;
    } bsc_cfg_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [63:0] wdata;
        logic [7:0]  be;
    } bsc_req_t;
endpackage

// File: bsc_decode.sv
// strap code decoder
`timescale 1ns/100ps
`include "bsc_map.svh"
module bsc_decode (
    input  wire logic [3:0]       code,
    output bsc_pkg::bsc_cfg_t     cfg
);
    import bsc_pkg::*;
    // purely combinational table of the strap codes
    always_comb begin
        cfg = '0;
        cfg.pad_vddq           = 1'b1;
        cfg.double_host_link_n = 1'b1;
        if (code == `BSC_CODE_GFX_LO || code == `BSC_CODE_GFX_HI) begin
            cfg.gfx_bus            = 1'b1;
            cfg.pad_vddq           = code[0];
            cfg.double_host_link_n = 1'b0;
        end else if (!code[3]) begin
            cfg.olr_single         = code[1];
            cfg.olr_dual           = !code[1];
            cfg.double_host_link_n = code[2];
        end else begin
            // single link unless code 1011
            cfg.double_host_link_n = (code != `BSC_CODE_DUAL_A);
            cfg.full_req      = (code == `BSC_CODE_PCI6_A) ||
                                (code == `BSC_CODE_PCI6_BOOT);
            cfg.boot_from_bus = (code == `BSC_CODE_PCI6_BOOT) ||
                                (code == `BSC_CODE_BOOT_X);
            cfg.reserved_code = (code == `BSC_CODE_UNUSED);
        end
    end
endmodule

// File: bsc_board_model.sv
// board straps and power-up reset source
`timescale 1ns/100ps
module bsc_board_model (
    input  wire logic       clk,
    input  wire logic       pwr_ok,
    input  wire logic [3:0] code,
    output logic            power_up_reset_n,
    output logic [3:0]      strap = 4'h0
);
    logic [2:0] hold_q = 3'h0;
    assign power_up_reset_n = hold_q[0];
    // straps hold two edges past release, then the shared pins go busy
    always @(posedge clk) begin
        hold_q <= {hold_q[1:0], pwr_ok};
        strap <= &hold_q ? ~strap : code;
    end
endmodule

// File: bsc_top_monitor.sv
// assertion checker for the bus mode strap block
`timescale 1ns/100ps
module bsc_top_monitor (
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic        HARD_RESET,
    input wire logic [63:0] RDATA,
    input wire logic        RVALID,
    input wire logic        BUS_SPEED_O,
    input wire logic        BUS_SPEED_OE,
    input wire logic        BUS_RESET_N,
    input wire logic        ARB_SIXTH_ENABLE
);
    import bsc_pkg::*;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // a mode read always shows the pad or the graphics flag
    wire logic m = RVALID && (RDATA[6] || RDATA[0]);
    force_low_a: assert property (BUS_SPEED_OE |-> !BUS_SPEED_O)
        else $error("speed pin driven high");
    // the pin lags the held flag by one register stage
    hard_hold_a: assert property (HARD_RESET |-> ##2 !BUS_RESET_N)
        else $error("bus reset released in hard reset");
    six_sense_a: assert property (m && RDATA[3] |-> !RDATA[7])
        else $error("speed sense set with six masters");
    six_oe_a: assert property (m && RDATA[3] |-> !BUS_SPEED_OE)
        else $error("speed pin driven with six masters");
    sixth_arb_a: assert property (m && !RDATA[3] |-> !ARB_SIXTH_ENABLE)
        else $error("sixth slot enabled");
    gfx_plain_a: assert property (m && RDATA[0] |-> RDATA[5:1] == 5'h00)
        else $error("graphics bus with other flags");
    olr_excl_a: assert property (m |-> !(RDATA[1] && RDATA[2]))
        else $error("both replacement flags set");
    six_link_a: assert property (m && RDATA[3] |-> RDATA[5])
        else $error("six masters with dual links");
    cover property (m && RDATA[3]);
    cover property (m && RDATA[0]);
    cover property (m && RDATA[4]);
endmodule

// File: testbench.sv
// self-checking bench for the bus mode strap block
`timescale 1ns/100ps
module testbench;
    import bsc_pkg::*;
    logic clk = 0, rst_n = 0, pwr_ok = 0, hard = 1, fw = 0, sense = 0;
    logic areq = 0, six = 0, pun, rv, so, soe, brn, arb, nar, pad, gfx;
    logic [3:0]  code = 0, kq = 0, strap;
    logic [15:0] lfsr = 16'hF1A0;
    logic [63:0] rdat, w = 64'h0;
    bsc_req_t    req = '0;
    bsc_opsel_t  ops;
    int          bad_count = 0, samples_checked = 0;
    // 200 MHz bench clock
    initial forever #2.5 clk = ~clk;
    bsc_board_model i_bsc_board_model (.clk, .pwr_ok, .code,
        .power_up_reset_n(pun), .strap);
    bsc_top i_bsc_top (.CLK(clk), .RST_N(rst_n), .POWER_UP_RESET_N(pun),
        .STRAP(strap), .HARD_RESET(hard), .FW_BUS_RESET_RELEASE(fw),
        .BUS_SPEED_SENSE_IN(sense), .ARB_SIXTH_ENABLE_REQ(areq), .REQ(req),
        .RDATA(rdat), .RVALID(rv), .BUS_SPEED_O(so), .BUS_SPEED_OE(soe),
        .BUS_RESET_N(brn), .ARB_SIXTH_ENABLE(arb), .NARROW_INITIATOR(nar),
        .PAD_HIGH_VOLT(pad), .GFX_BUS(gfx), .BUS_OPERATING_SELECT(ops));
    // reference mode word from the strap code and the written controls
    function automatic logic [63:0] exp_mode(logic [3:0] k);
        return {52'h0, k, sense & !six, code != 4'h8, code[2],
            code[3:1] == 3'h6, six, !code[3] & !code[1],
            !code[3] & code[1], code[3:1] == 3'h4};
    endfunction
    task automatic chk(string n, logic [63:0] e, logic [63:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // one register access held for one edge; a read is compared with e
    task automatic io(logic wr, logic [11:0] a, logic [63:0] e);
        req = '{wr, !wr, a, e, 8'hFF};
        @(negedge clk);
        chk("rvalid", !wr, rv);
        if (!wr) chk("read", e, rdat);
        req = '0;
        @(negedge clk);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard, well above the few hundred cycles the run needs
    initial begin
        repeat (1000) @(posedge clk);
        bad_count++;
        complete_run();
    end
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1;
        for (int i = 0; i < 16; i++) begin
            if (i == 10) continue;
            code = 4'(i);
            six = i == 14 || i == 12;
            lfsr = {lfsr[14:0], ^(lfsr & 16'hB400)};
            sense = lfsr[0];
            areq = lfsr[1];
            // operating field written back unchanged, the rest random
            w = {lfsr, lfsr, lfsr, lfsr[15:11], kq[2:1], lfsr[8:0]};
            pwr_ok = 0;
            repeat (4) @(negedge clk);
            pwr_ok = 1;
            repeat (6) @(negedge clk);
            io(0, 12'h0620, exp_mode(kq));
            hard = 0;
            repeat (3) @(negedge clk);
            chk("boot", i == 12 || i == 13, brn);
            fw = 1;
            io(1, 12'h0620, w);
            fw = 0;
            kq = w[11:8];
            chk("fw release", 1, brn);
            hard = 1;
            io(0, 12'h0620, exp_mode(kq));
            io(0, 12'h0628, 64'h0);
            chk("oe", {kq[0] & !six, areq & six}, {soe, arb});
            chk("ctl", kq[3:1], {nar, ops});
            chk("pad", code != 4'h8, pad);
            chk("gfx pins", {code[3:1] == 3'h4, 1'b0}, {gfx, so});
        end
        complete_run();
    end
endmodule
bind bsc_top bsc_top_monitor i_bsc_top_monitor (.CLK, .RST_N, .HARD_RESET,
    .RDATA, .RVALID, .BUS_SPEED_O, .BUS_SPEED_OE, .BUS_RESET_N,
    .ARB_SIXTH_ENABLE);
